/* File: src/alu_ind_pkg.sv */
package alu_ind_pkg;

	// ----------------------------------------
	// instruction and mode encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_INCREMENT_FILE = 3'b000,
		OP_OR_ACCUM_WITH_FILE = 3'b001,
		OP_SHIFT_LEFT_LOGICAL = 3'b010,
		OP_SHIFT_RIGHT_LOGICAL = 3'b011,
		OP_COPY_FILE = 3'b100,
		OP_LOAD_INDIRECT_TO_ACCUM = 3'b101
	} opcode_type;

	typedef enum logic [1:0] {
		MODE_PRE_INC = 2'b00,
		MODE_PRE_DEC = 2'b01,
		MODE_POST_INC = 2'b10,
		MODE_POST_DEC = 2'b11
	} pointer_update_select_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_EXEC = 2'b10
	} state_type;

	// ----------------------------------------
	// register port map and fields
	// ----------------------------------------
	localparam logic [3:0] REG_ACCUM = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_PTR0_LO = 4'h2;
	localparam logic [3:0] REG_PTR0_HI = 4'h3;
	localparam logic [3:0] REG_PTR1_LO = 4'h4;
	localparam logic [3:0] REG_PTR1_HI = 4'h5;
	localparam int ZERO_BIT = 0;
	localparam int CARRY_BIT = 1;

	// ----------------------------------------
	// reset values and address constants
	// ----------------------------------------
	localparam logic [7:0] ACCUM_RST = 8'h00;
	localparam logic ZERO_RST = 1'b0;
	localparam logic CARRY_RST = 1'b0;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [6:0] WIN0_FILE = 7'h00;
	localparam logic [6:0] WIN1_FILE = 7'h01;
	localparam logic [8:0] FILE_HI = 9'h000;
	localparam logic DEST_ACCUM = 1'b0;
	localparam logic DEST_FILE = 1'b1;

endpackage : alu_ind_pkg

/* File: src/ptr_step.sv */
`timescale 1ns/1ps
`default_nettype none

module ptr_step (
	input wire logic [15:0] ptr,
	input wire logic [1:0] mode,
	input wire logic rel,
	input wire logic [5:0] offset,
	output logic [15:0] eff_addr,
	output logic [15:0] next_ptr
);

	// ----------------------------------------
	// pointer arithmetic
	// ----------------------------------------
	wire [15:0] ptr_inc = ptr + 16'h0001; // 16 bit sum wraps FFFF to 0000
	wire [15:0] ptr_dec = ptr - 16'h0001; // 0000 wraps to FFFF
	wire [15:0] ptr_rel = ptr + {{10{offset[5]}}, offset}; // signed -32..31
	wire is_inc = (mode == alu_ind_pkg::MODE_PRE_INC) || (mode == alu_ind_pkg::MODE_POST_INC);
	wire is_pre = (mode == alu_ind_pkg::MODE_PRE_INC) || (mode == alu_ind_pkg::MODE_PRE_DEC);
	wire [15:0] stepped = is_inc ? ptr_inc : ptr_dec;

	// pre modes address the stepped value, post modes the old one
	assign eff_addr = rel ? ptr_rel : (is_pre ? stepped : ptr);
	// offset form leaves the pointer alone
	assign next_ptr = rel ? ptr : stepped;

endmodule : ptr_step

`default_nettype wire

/* File: src/byte_alu_indirect.sv */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - destination bit 0 writes accumulator, 1 writes back to file register, except indirect load, which always writes accumulator
// - increment adds one to file register 0..127, only zero flag changes
// - OR of accumulator and file register, routed by destination, only zero flag
// - left shift: bit 7 to carry, bits 6:0 up, zero in; carry and zero
// - right shift: bit 0 to carry, bits 7:1 down, zero in; carry and zero
// - copy moves file to destination, sets zero flag, done two cycles after capture like the rest
// - indirect load picks pointer by index, loads accumulator, updates zero
// - window registers map onto memory at the pointer, no own storage
// - mode 00 preinc, 01 predec, 10 postinc, 11 postdec
// - pre modes use stepped address, post use old; pointer steps unless offset form
// - offset form addresses pointer plus signed -32..31, pointer unchanged
// - pointers are 16 bit and wrap at both ends
// - pointer stepping never touches status flags
module byte_alu_indirect (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic INSTR_VALID,
	output logic INSTR_READY,
	input wire logic [2:0] INSTR_OP,
	input wire logic INSTR_DEST,
	input wire logic [6:0] INSTR_FILE,
	input wire logic INSTR_PTR_SEL,
	input wire logic INSTR_REL,
	input wire logic [1:0] INSTR_MODE,
	input wire logic [5:0] INSTR_OFFSET,
	output logic INSTR_DONE,
	output logic [15:0] MEM_ADDR,
	output logic MEM_RD,
	input wire logic [7:0] MEM_RDATA,
	output logic MEM_WR,
	output logic [7:0] MEM_WDATA,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// port offset of one pointer byte
	function automatic logic [3:0] ptr_reg(input logic idx, input logic hi);
		if (idx == 1'b0) begin
			return hi ? alu_ind_pkg::REG_PTR0_HI : alu_ind_pkg::REG_PTR0_LO;
		end
		return hi ? alu_ind_pkg::REG_PTR1_HI : alu_ind_pkg::REG_PTR1_LO;
	endfunction : ptr_reg

	// window file addresses redirect to the pointer value
	function automatic logic [15:0] file_to_addr(input logic [6:0] f, input logic [15:0] p0,
			input logic [15:0] p1);
		if (f == alu_ind_pkg::WIN0_FILE) begin
			return p0;
		end else if (f == alu_ind_pkg::WIN1_FILE) begin
			return p1;
		end
		return {alu_ind_pkg::FILE_HI, f};
	endfunction : file_to_addr

	// ----------------------------------------
	// state
	// ----------------------------------------
	alu_ind_pkg::state_type state_q;
	alu_ind_pkg::state_type state_d;
	logic [2:0] op_q;
	logic dest_q;
	logic [15:0] addr_q;
	logic rd_q;
	logic wr_q;
	logic done_q;
	logic [7:0] wdata_q;
	logic [7:0] accum_q;
	logic [7:0] accum_d;
	logic zero_q;
	logic zero_d;
	logic carry_q;
	logic carry_d;
	logic [7:0] rdata_q;
	logic [15:0] ptr_q [0:1];
	logic [15:0] ptr_d [0:1];
	logic [7:0] status_w;

	// ----------------------------------------
	// instruction capture and address
	// ----------------------------------------
	wire capture = INSTR_VALID && (state_q == alu_ind_pkg::ST_IDLE);
	wire exec = (state_q == alu_ind_pkg::ST_EXEC);
	wire is_load_in = (INSTR_OP == alu_ind_pkg::OP_LOAD_INDIRECT_TO_ACCUM);
	wire [15:0] sel_ptr = ptr_q[INSTR_PTR_SEL]; // one-bit index picks the pointer
	wire [15:0] step_addr;
	wire [15:0] step_next;
	wire [15:0] file_addr = file_to_addr(INSTR_FILE, ptr_q[0], ptr_q[1]);
	wire [15:0] cap_addr = is_load_in ? step_addr : file_addr;

	// mode decode and 16-bit wrap live in the step unit
	ptr_step i_ptr_step (
		.ptr(sel_ptr),
		.mode(INSTR_MODE),
		.rel(INSTR_REL),
		.offset(INSTR_OFFSET),
		.eff_addr(step_addr),
		.next_ptr(step_next)
	);

	// ----------------------------------------
	// execute datapath
	// ----------------------------------------
	wire [7:0] inc_w = MEM_RDATA + 8'h01;
	wire [7:0] or_w = accum_q | MEM_RDATA;
	wire [7:0] shl_w = {MEM_RDATA[6:0], 1'b0}; // zero into bit 0
	wire [7:0] shr_w = {1'b0, MEM_RDATA[7:1]}; // zero into bit 7
	wire op_inc = (op_q == alu_ind_pkg::OP_INCREMENT_FILE);
	wire op_or = (op_q == alu_ind_pkg::OP_OR_ACCUM_WITH_FILE);
	wire op_shl = (op_q == alu_ind_pkg::OP_SHIFT_LEFT_LOGICAL);
	wire op_shr = (op_q == alu_ind_pkg::OP_SHIFT_RIGHT_LOGICAL);
	wire op_copy = (op_q == alu_ind_pkg::OP_COPY_FILE);
	wire op_load = (op_q == alu_ind_pkg::OP_LOAD_INDIRECT_TO_ACCUM);
	wire op_known = op_inc || op_or || op_shl || op_shr || op_copy || op_load;
	wire is_shift = op_shl || op_shr;
	// copy and load pass the fetched byte through untouched
	wire [7:0] result_w = op_inc ? inc_w : op_or ? or_w : op_shl ? shl_w : op_shr ? shr_w :
		MEM_RDATA;
	wire carry_w = op_shl ? MEM_RDATA[7] : MEM_RDATA[0];
	wire result_zero = (result_w == 8'h00);
	// the load always lands in the accumulator whatever the destination bit
	wire to_file = exec && op_known && !op_load && (dest_q == alu_ind_pkg::DEST_FILE);
	wire to_accum = exec && op_known && !to_file;

	// ----------------------------------------
	// register port decode
	// ----------------------------------------
	wire sw_wr_accum = REG_WR && (REG_ADDR == alu_ind_pkg::REG_ACCUM);
	wire sw_wr_status = REG_WR && (REG_ADDR == alu_ind_pkg::REG_STATUS);
	wire sw_wr_ptr = REG_WR && ((REG_ADDR == ptr_reg(1'b0, 1'b0)) ||
		(REG_ADDR == ptr_reg(1'b0, 1'b1)) || (REG_ADDR == ptr_reg(1'b1, 1'b0)) ||
		(REG_ADDR == ptr_reg(1'b1, 1'b1)));
	wire [7:0] rd_mux = (REG_ADDR == alu_ind_pkg::REG_ACCUM) ? accum_q :
		(REG_ADDR == alu_ind_pkg::REG_STATUS) ? status_w :
		(REG_ADDR == ptr_reg(1'b0, 1'b0)) ? ptr_q[0][7:0] :
		(REG_ADDR == ptr_reg(1'b0, 1'b1)) ? ptr_q[0][15:8] :
		(REG_ADDR == ptr_reg(1'b1, 1'b0)) ? ptr_q[1][7:0] :
		(REG_ADDR == ptr_reg(1'b1, 1'b1)) ? ptr_q[1][15:8] : 8'h00;

	// status byte, unused bits read zero
	always_comb begin
		status_w = 8'h00;
		status_w[alu_ind_pkg::ZERO_BIT] = zero_q;
		status_w[alu_ind_pkg::CARRY_BIT] = carry_q;
	end

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	// hardware updates win over a same-cycle software write
	assign accum_d = to_accum ? result_w : (sw_wr_accum ? REG_WDATA : accum_q);
	// every known instruction here updates zero
	assign zero_d = (exec && op_known) ? result_zero :
		(sw_wr_status ? REG_WDATA[alu_ind_pkg::ZERO_BIT] : zero_q);
	// only the shifts touch carry; stepping leaves it alone
	assign carry_d = (exec && is_shift) ? carry_w :
		(sw_wr_status ? REG_WDATA[alu_ind_pkg::CARRY_BIT] : carry_q);

	// pointer bytes from the port, stepping by the load wins
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ptr_d[i] = ptr_q[i];
			if (REG_WR && (REG_ADDR == ptr_reg(i[0], 1'b0))) begin
				ptr_d[i][7:0] = REG_WDATA;
			end
			if (REG_WR && (REG_ADDR == ptr_reg(i[0], 1'b1))) begin
				ptr_d[i][15:8] = REG_WDATA;
			end
			if (capture && is_load_in && (INSTR_PTR_SEL == i[0])) begin
				ptr_d[i] = step_next;
			end
		end
	end

	// fetch one cycle, execute the next; one instruction per pass
	always_comb begin
		state_d = state_q;
		case (state_q)
			alu_ind_pkg::ST_IDLE: begin
				if (capture) begin
					state_d = alu_ind_pkg::ST_READ;
				end
			end
			alu_ind_pkg::ST_READ: begin
				state_d = alu_ind_pkg::ST_EXEC;
			end
			alu_ind_pkg::ST_EXEC: begin
				state_d = alu_ind_pkg::ST_IDLE;
			end
			default: begin
				state_d = alu_ind_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// sequencing and memory strobes
	always_ff @(posedge MCLK) begin
		if (RST) begin
			state_q <= alu_ind_pkg::ST_IDLE;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rd_q <= capture;
			wr_q <= to_file; // write back into the file register
			done_q <= exec;
		end
	end

	// latched instruction fields and address
	always_ff @(posedge MCLK) begin
		if (RST) begin
			op_q <= 3'h0;
			dest_q <= alu_ind_pkg::DEST_ACCUM;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
		end else begin
			if (capture) begin
				op_q <= INSTR_OP;
				dest_q <= INSTR_DEST;
				addr_q <= cap_addr; // same address serves read and write-back
			end
			if (to_file) begin
				wdata_q <= result_w;
			end
		end
	end

	// architectural state
	always_ff @(posedge MCLK) begin
		if (RST) begin
			accum_q <= alu_ind_pkg::ACCUM_RST;
			zero_q <= alu_ind_pkg::ZERO_RST;
			carry_q <= alu_ind_pkg::CARRY_RST;
			ptr_q[0] <= alu_ind_pkg::PTR_RST;
			ptr_q[1] <= alu_ind_pkg::PTR_RST;
		end else begin
			accum_q <= accum_d;
			zero_q <= zero_d;
			carry_q <= carry_d;
			ptr_q[0] <= ptr_d[0];
			ptr_q[1] <= ptr_d[1];
		end
	end

	// port read data, one cycle after the strobe
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rdata_q <= 8'h00;
		end else if (REG_RD) begin
			rdata_q <= rd_mux;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign INSTR_READY = (state_q == alu_ind_pkg::ST_IDLE);
	assign INSTR_DONE = done_q;
	assign MEM_ADDR = addr_q;
	assign MEM_RD = rd_q;
	assign MEM_WR = wr_q;
	assign MEM_WDATA = wdata_q;
	assign REG_RDATA = rdata_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_capture;
		capture;
	endsequence

	sequence s_access;
		rd_q ##1 (exec && !rd_q) ##1 (done_q && INSTR_READY);
	endsequence

	a_access_order: assert property (
		@(posedge MCLK) disable iff (RST) s_capture |=> s_access)
		else $error("instruction did not read then execute then finish");

	a_inc_accum: assert property (
		@(posedge MCLK) disable iff (RST)
		exec && op_inc && (dest_q == alu_ind_pkg::DEST_ACCUM) |=>
		(accum_q == $past(MEM_RDATA) + 8'h01) && !MEM_WR)
		else $error("increment to accumulator wrong");

	a_or_file: assert property (
		@(posedge MCLK) disable iff (RST)
		exec && op_or && (dest_q == alu_ind_pkg::DEST_FILE) |=>
		MEM_WR && (MEM_WDATA == ($past(accum_q) | $past(MEM_RDATA))) &&
		(accum_q == $past(accum_q)) ##1 !MEM_WR)
		else $error("or write-back to file wrong");

	a_shl_carry: assert property (
		@(posedge MCLK) disable iff (RST)
		exec && op_shl && !sw_wr_status |=> (carry_q == $past(MEM_RDATA[7])) &&
		(zero_q == ($past(MEM_RDATA[6:0]) == 7'h00)))
		else $error("left shift flags wrong");

	a_shr_carry: assert property (
		@(posedge MCLK) disable iff (RST)
		exec && op_shr && (dest_q == alu_ind_pkg::DEST_ACCUM) |=>
		(carry_q == $past(MEM_RDATA[0])) && (accum_q == {1'b0, $past(MEM_RDATA[7:1])}))
		else $error("right shift result or carry wrong");

	a_copy_zero: assert property (
		@(posedge MCLK) disable iff (RST)
		exec && op_copy |=> zero_q == ($past(MEM_RDATA) == 8'h00))
		else $error("copy zero flag wrong");

	a_load_accum: assert property (
		@(posedge MCLK) disable iff (RST)
		exec && op_load |=> (accum_q == $past(MEM_RDATA)) && !MEM_WR)
		else $error("indirect load did not fill accumulator");

	a_window_map: assert property (
		@(posedge MCLK) disable iff (RST)
		capture && !is_load_in && (INSTR_FILE == alu_ind_pkg::WIN1_FILE) |=>
		MEM_ADDR == $past(ptr_q[1]))
		else $error("window access not redirected to pointer");

	a_pre_inc: assert property (
		@(posedge MCLK) disable iff (RST)
		capture && is_load_in && !INSTR_REL && (INSTR_MODE == alu_ind_pkg::MODE_PRE_INC) |=>
		(MEM_ADDR == $past(sel_ptr) + 16'h0001) &&
		(ptr_q[$past(INSTR_PTR_SEL)] == $past(sel_ptr) + 16'h0001))
		else $error("preincrement address or pointer wrong");

	a_post_dec: assert property (
		@(posedge MCLK) disable iff (RST)
		capture && is_load_in && !INSTR_REL && (INSTR_MODE == alu_ind_pkg::MODE_POST_DEC) |=>
		(MEM_ADDR == $past(sel_ptr)) &&
		(ptr_q[$past(INSTR_PTR_SEL)] == $past(sel_ptr) - 16'h0001))
		else $error("postdecrement address or pointer wrong");

	a_rel_hold: assert property (
		@(posedge MCLK) disable iff (RST)
		capture && is_load_in && INSTR_REL && !sw_wr_ptr |=>
		(ptr_q[$past(INSTR_PTR_SEL)] == $past(sel_ptr)) &&
		(MEM_ADDR == $past(sel_ptr) + {{10{$past(INSTR_OFFSET[5])}}, $past(INSTR_OFFSET)}))
		else $error("relative form moved pointer or used wrong address");

	a_carry_hold: assert property (
		@(posedge MCLK) disable iff (RST)
		exec && !is_shift && !sw_wr_status |=> $stable(carry_q))
		else $error("carry changed by non-shift instruction");

endmodule : byte_alu_indirect

`default_nettype wire

/* File: verif/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// data memory seen from the datapath
// ----------------------------------------
module mem_model (
	input wire logic clk,
	input wire logic [15:0] addr,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] rdata_q;

	// known pattern so a wrong address shows up as a wrong byte
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'h5A;
		end
		rdata_q = 8'h00;
	end

	// data valid only in the cycle after the strobe, inverted otherwise
	always @(posedge clk) begin
		if (wr) begin
			mem[addr] <= wdata;
		end
		if (rd) begin
			rdata_q <= mem[addr];
		end else begin
			rdata_q <= ~rdata_q;
		end
	end

	assign rdata = rdata_q;
endmodule : mem_model

`default_nettype wire

/* File: verif/test_byte_alu_indirect.sv */
`timescale 1ns/1ps
`default_nettype none

module test_byte_alu_indirect;
	// ----------------------------------------
	// stimulus signals
	// ----------------------------------------
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic instr_valid = 1'b0;
	logic instr_ready;
	logic [2:0] instr_op = 3'h0;
	logic instr_dest = 1'b0;
	logic [6:0] instr_file = 7'h00;
	logic instr_ptr_sel = 1'b0;
	logic instr_rel = 1'b0;
	logic [1:0] instr_mode = 2'h0;
	logic [5:0] instr_offset = 6'h00;
	logic instr_done;
	logic [15:0] mem_addr;
	logic mem_rd;
	logic [7:0] mem_rdata;
	logic mem_wr;
	logic [7:0] mem_wdata;
	logic [3:0] rg_addr = 4'h0;
	logic [7:0] rg_wdata = 8'h00;
	logic rg_wr = 1'b0;
	logic rg_rd = 1'b0;
	logic [7:0] rg_rdata;
	int mismatches = 0;
	int compares = 0;

	// 200 MHz core clock
	initial begin
		forever #2.5 mclk = ~mclk;
	end

	byte_alu_indirect i_byte_alu_indirect (.MCLK(mclk), .RST(rst), .INSTR_VALID(instr_valid),
		.INSTR_READY(instr_ready), .INSTR_OP(instr_op), .INSTR_DEST(instr_dest),
		.INSTR_FILE(instr_file), .INSTR_PTR_SEL(instr_ptr_sel), .INSTR_REL(instr_rel),
		.INSTR_MODE(instr_mode), .INSTR_OFFSET(instr_offset), .INSTR_DONE(instr_done),
		.MEM_ADDR(mem_addr), .MEM_RD(mem_rd), .MEM_RDATA(mem_rdata), .MEM_WR(mem_wr),
		.MEM_WDATA(mem_wdata), .REG_ADDR(rg_addr), .REG_WDATA(rg_wdata), .REG_WR(rg_wr),
		.REG_RD(rg_rd), .REG_RDATA(rg_rdata));

	mem_model i_mem_model (.clk(mclk), .addr(mem_addr), .rd(mem_rd), .wr(mem_wr),
		.wdata(mem_wdata), .rdata(mem_rdata));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		rg_addr <= a;
		rg_wdata <= d;
		rg_wr <= 1'b1;
		@(posedge mclk);
		rg_wr <= 1'b0;
	endtask : wr_reg

	// read data appear the cycle after the strobe and hold until the next strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		rg_addr <= a;
		rg_rd <= 1'b1;
		@(posedge mclk);
		rg_rd <= 1'b0;
		#1 d = rg_rdata;
	endtask : rd_reg

	task automatic wr_ptr(input logic s, input logic [15:0] p);
		wr_reg(s ? alu_ind_pkg::REG_PTR1_LO : alu_ind_pkg::REG_PTR0_LO, p[7:0]);
		wr_reg(s ? alu_ind_pkg::REG_PTR1_HI : alu_ind_pkg::REG_PTR0_HI, p[15:8]);
	endtask : wr_ptr

	task automatic rd_ptr(input logic s, output logic [15:0] p);
		rd_reg(s ? alu_ind_pkg::REG_PTR1_LO : alu_ind_pkg::REG_PTR0_LO, p[7:0]);
		rd_reg(s ? alu_ind_pkg::REG_PTR1_HI : alu_ind_pkg::REG_PTR0_HI, p[15:8]);
	endtask : rd_ptr

	// one instruction; done stands two edges after the taking edge, ready drops meanwhile
	task automatic exec(input logic [2:0] op, input logic d, input logic [6:0] f,
			input logic s, input logic r, input logic [1:0] m, input logic [5:0] o);
		int n;
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_dest <= d;
		instr_file <= f;
		instr_ptr_sel <= s;
		instr_rel <= r;
		instr_mode <= m;
		instr_offset <= o;
		@(posedge mclk);
		instr_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
			if (n == 1) begin
				check("ready_busy", 16'(instr_ready), 16'h0000);
			end
		end while (instr_done !== 1'b1 && n < 8);
		check("done_delay", 16'(n), 16'h0002);
		check("ready_again", 16'(instr_ready), 16'h0001);
		if (n == 8) begin
			complete_run();
		end
	endtask : exec

	// byte op on a file byte living at memory address ma
	task automatic run_byte(input alu_ind_pkg::opcode_type op, input logic d, input logic [6:0] f,
			input logic [15:0] ma, input logic [7:0] fv, input logic [7:0] acc,
			input logic [7:0] st);
		logic [7:0] r;
		logic [7:0] v;
		logic c;
		i_mem_model.mem[ma] = fv;
		wr_reg(alu_ind_pkg::REG_ACCUM, acc);
		wr_reg(alu_ind_pkg::REG_STATUS, st);
		c = st[1];
		case (op)
			alu_ind_pkg::OP_INCREMENT_FILE: r = fv + 8'h01;
			alu_ind_pkg::OP_OR_ACCUM_WITH_FILE: r = acc | fv;
			alu_ind_pkg::OP_SHIFT_LEFT_LOGICAL: {c, r} = {fv, 1'b0};
			alu_ind_pkg::OP_SHIFT_RIGHT_LOGICAL: {r, c} = {1'b0, fv};
			default: r = fv;
		endcase
		exec(op, d, f, 1'b0, 1'b0, 2'h0, 6'h00);
		rd_reg(alu_ind_pkg::REG_ACCUM, v);
		check("accum", 16'(v), 16'(d ? acc : r));
		rd_reg(alu_ind_pkg::REG_STATUS, v);
		check("status", 16'(v), {14'h0000, c, r == 8'h00});
		check("file", 16'(i_mem_model.mem[ma]), 16'(d ? r : fv));
	endtask : run_byte

	// indirect load; wrong neighbours hold the inverse byte
	task automatic run_load(input logic s, input logic r, input logic [1:0] m,
			input logic [5:0] o, input logic [15:0] p, input logic [7:0] dv);
		logic [15:0] ea;
		logic [15:0] np;
		logic [15:0] q;
		logic [7:0] v;
		np = p;
		ea = p + {{10{o[5]}}, o};
		if (!r) begin
			np = m[0] ? p - 16'h0001 : p + 16'h0001;
			ea = m[1] ? p : np;
		end
		wr_ptr(s, p);
		wr_ptr(!s, 16'h7777);
		i_mem_model.mem[p - 16'h0001] = ~dv;
		i_mem_model.mem[p] = ~dv;
		i_mem_model.mem[p + 16'h0001] = ~dv;
		i_mem_model.mem[ea] = dv;
		wr_reg(alu_ind_pkg::REG_STATUS, 8'h02);
		exec(alu_ind_pkg::OP_LOAD_INDIRECT_TO_ACCUM, 1'b1, 7'h40, s, r, m, o);
		rd_reg(alu_ind_pkg::REG_ACCUM, v);
		check("load_data", 16'(v), 16'(dv));
		rd_reg(alu_ind_pkg::REG_STATUS, v);
		check("load_status", 16'(v), {15'h0001, dv == 8'h00});
		rd_ptr(s, q);
		check("ptr_after", q, np);
		rd_ptr(!s, q);
		check("other_ptr", q, 16'h7777);
	endtask : run_load

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] v;
		for (int a = 0; a < 7; a++) begin
			rd_reg(a == 6 ? 4'hF : 4'(a), v);
			check("reset_reg", 16'(v), 16'h0000);
		end
	endtask : t_reset

	task automatic t_byte_ops;
		logic [7:0] v;
		run_byte(alu_ind_pkg::OP_INCREMENT_FILE, 1'b0, 7'h7F, 16'h007F, 8'hFF, 8'h33, 8'h02);
		run_byte(alu_ind_pkg::OP_INCREMENT_FILE, 1'b1, 7'h05, 16'h0005, 8'h41, 8'h00, 8'h01);
		run_byte(alu_ind_pkg::OP_OR_ACCUM_WITH_FILE, 1'b0, 7'h10, 16'h0010, 8'h0F, 8'hF0, 8'h03);
		run_byte(alu_ind_pkg::OP_OR_ACCUM_WITH_FILE, 1'b1, 7'h11, 16'h0011, 8'h00, 8'h00, 8'h02);
		run_byte(alu_ind_pkg::OP_SHIFT_LEFT_LOGICAL, 1'b0, 7'h20, 16'h0020, 8'h80, 8'h11, 8'h00);
		run_byte(alu_ind_pkg::OP_SHIFT_LEFT_LOGICAL, 1'b1, 7'h21, 16'h0021, 8'h41, 8'h11, 8'h03);
		run_byte(alu_ind_pkg::OP_SHIFT_RIGHT_LOGICAL, 1'b0, 7'h22, 16'h0022, 8'h01, 8'h11, 8'h00);
		run_byte(alu_ind_pkg::OP_SHIFT_RIGHT_LOGICAL, 1'b1, 7'h23, 16'h0023, 8'h82, 8'h11, 8'h03);
		run_byte(alu_ind_pkg::OP_COPY_FILE, 1'b0, 7'h30, 16'h0030, 8'h00, 8'h55, 8'h02);
		run_byte(alu_ind_pkg::OP_COPY_FILE, 1'b1, 7'h31, 16'h0031, 8'h9A, 8'h55, 8'h01);
		// an undecoded opcode runs the sequence but must leave accumulator and file alone
		exec(3'b110, 1'b1, 7'h30, 1'b0, 1'b0, 2'h0, 6'h00);
		rd_reg(alu_ind_pkg::REG_ACCUM, v);
		check("nop_accum", 16'(v), 16'h0055);
		check("nop_file", 16'(i_mem_model.mem[16'h0030]), 16'h0000);
	endtask : t_byte_ops

	// window files reach memory at the pointer and leave it unstepped
	task automatic t_window;
		logic [15:0] q;
		wr_ptr(1'b0, 16'h1234);
		run_byte(alu_ind_pkg::OP_COPY_FILE, 1'b0, 7'h00, 16'h1234, 8'h00, 8'h66, 8'h00);
		rd_ptr(1'b0, q);
		check("win0_ptr", q, 16'h1234);
		wr_ptr(1'b1, 16'hABCD);
		run_byte(alu_ind_pkg::OP_INCREMENT_FILE, 1'b1, 7'h01, 16'hABCD, 8'h7F, 8'h66, 8'h00);
		rd_ptr(1'b1, q);
		check("win1_ptr", q, 16'hABCD);
	endtask : t_window

	// every mode at the wrap points, then both offset extremes
	task automatic t_indirect;
		run_load(1'b0, 1'b0, 2'b00, 6'h00, 16'hFFFF, 8'h00);
		run_load(1'b1, 1'b0, 2'b01, 6'h00, 16'h0000, 8'h3C);
		run_load(1'b0, 1'b0, 2'b10, 6'h00, 16'hFFFF, 8'h81);
		run_load(1'b1, 1'b0, 2'b11, 6'h00, 16'h0000, 8'h00);
		run_load(1'b0, 1'b1, 2'b10, 6'h20, 16'h0010, 8'h7E);
		run_load(1'b1, 1'b1, 2'b01, 6'h1F, 16'hFFF0, 8'hC3);
	endtask : t_indirect

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_byte_ops();
		t_window();
		t_indirect();
		complete_run();
	end
endmodule : test_byte_alu_indirect

`default_nettype wire
